// ---- hdl/coc_pkg.sv ----
// shared constants, codes and carriers of the comparator conditioning block
package coc_pkg;
	// register port geometry
	localparam int unsigned CTRL_W = 16;
	localparam int unsigned DAC_W = 12;
	localparam int unsigned ADDR_W = 4;
	// register word addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_DAC = 4'h1;
	// control field positions
	localparam int unsigned B_ENABLE = 15;
	localparam int unsigned B_IDLE_STOP = 13;
	localparam int unsigned B_HYS_HI = 12;
	localparam int unsigned B_HYS_LO = 11;
	localparam int unsigned B_FILT_EN = 10;
	localparam int unsigned B_FCLK_SEL = 9;
	localparam int unsigned B_REF_OE = 8;
	localparam int unsigned B_INPUT_SELECT_HI = 7;
	localparam int unsigned B_INPUT_SELECT_LO = 6;
	localparam int unsigned B_EXT_REF = 5;
	localparam int unsigned B_HYS_POL = 4;
	localparam int unsigned B_STATE = 3;
	localparam int unsigned B_ALT = 2;
	localparam int unsigned B_POL = 1;
	localparam int unsigned B_RANGE = 0;
	// reset values and writable bits (14 unused, 3 hardware owned)
	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'hBFF7;
	localparam logic [DAC_W-1:0] DAC_RESET = 12'h000;
	localparam logic [CTRL_W-DAC_W-1:0] DAC_PAD = 4'h0;
	localparam logic [CTRL_W-1:0] RD_ZERO = 16'h0000;
	// timing counts, in ticks of the selected conditioning clock
	localparam int unsigned CNT_W = 2;
	localparam logic [CNT_W-1:0] STRETCH_TICKS = 2'h3;
	localparam logic [CNT_W-1:0] FILTER_SAMPLES = 2'h3;
	localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 2'h1;
	// input mux selection towards the analog comparator
	typedef enum logic [2:0] {
		MUX_A, MUX_B, MUX_C, MUX_D, MUX_AMP1, MUX_AMP2, MUX_OFF
	} coc_mux_t;
	// reference source of the threshold converter
	typedef enum logic [1:0] {
		REF_INTERNAL, REF_SUPPLY, REF_EXTERNAL
	} coc_ref_t;
	// static controls for the analog comparator and converter
	typedef struct packed {
		logic power_en;
		coc_mux_t mux;
		coc_ref_t ref_src;
		logic [1:0] hyst_sel;
		logic hyst_pol;
		logic ref_pin_oe;
		logic [DAC_W-1:0] dac_code;
	} coc_analog_t;
	// consumers of the conditioned output
	typedef struct packed {
		logic irq;
		logic adc_trigger;
		logic current_limit;
		logic period_trunc;
		logic fault;
	} coc_event_t;
endpackage

// ---- hdl/coc_filter.sv ----
// debounce filter: a new level passes after a run of equal samples
module coc_filter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic tick,
	input wire logic in_lvl,
	output logic out_lvl
);
	import coc_pkg::*;

	logic [CNT_W-1:0] run_q; // samples seen that differ from output

	// count consecutive differing samples, restart on any match
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			run_q <= CNT_ZERO;
		end else if (in_lvl == out_lvl) begin
			run_q <= CNT_ZERO;
		end else if (tick) begin
			run_q <= (run_q == FILTER_SAMPLES - CNT_ONE) ? CNT_ZERO
				: run_q + CNT_ONE;
		end
	end

	// output moves only on the last sample of the run
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			out_lvl <= 1'b0;
		end else if (tick && in_lvl != out_lvl &&
			run_q == FILTER_SAMPLES - CNT_ONE) begin
			out_lvl <= in_lvl;
		end
	end
endmodule

// ---- hdl/coc_top.sv ----
// comparator control registers, stretcher, filter and output routing
//
// Implementation choices: the placing of the registers and strobed register access.
module coc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [coc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [coc_pkg::CTRL_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [coc_pkg::CTRL_W-1:0] reg_rdata,
	input wire logic comp_raw,
	input wire logic pwm_clk_pin,
	input wire logic device_idle,
	input wire logic device_sleep,
	input wire logic idle_stop_others,
	output logic idle_stop_request,
	output coc_pkg::coc_analog_t analog,
	output coc_pkg::coc_event_t events,
	output logic wake_request
);
	import coc_pkg::*;

	logic [CTRL_W-1:0] ctrl_q; // control word, software side
	logic [DAC_W-1:0] dac_q; // threshold code
	logic cap_q; // asynchronous event catcher
	logic s1_q; // first synchroniser stage
	logic s2_q; // second synchroniser stage
	logic s3_q; // third synchroniser stage
	logic seen_q; // accepted catcher level
	logic p1_q; // pwm clock, first stage
	logic p2_q; // pwm clock, second stage
	logic p3_q; // pwm clock, third stage
	logic pwm_lvl_q; // accepted pwm clock level
	logic [CNT_W-1:0] hold_q; // stretch ticks left
	logic cond_q; // conditioned output
	logic filt_out; // filter result
	logic raw_pol; // polarity-adjusted raw result
	logic pwm_rise; // accepted pwm clock rising edge
	logic tick; // selected conditioning clock tick
	logic seen_rise; // new event accepted this cycle
	logic stretched; // stretched level
	logic stop_now; // idle stop in force
	logic run; // block is operating
	logic sel_lvl; // filtered or bypassed level

	// operating conditions
	assign stop_now = device_idle && (ctrl_q[B_IDLE_STOP] ||
		idle_stop_others);
	assign run = ctrl_q[B_ENABLE] && !stop_now;

	// control register writes; hardware owned bits never take data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RESET;
		end else if (reg_we && reg_addr == ADDR_CTRL) begin
			ctrl_q <= reg_wdata & CTRL_WMASK;
		end
	end

	// threshold code, low twelve bits of the word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dac_q <= DAC_RESET;
		end else if (reg_we && reg_addr == ADDR_DAC) begin
			dac_q <= reg_wdata[DAC_W-1:0];
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= RD_ZERO;
		end else if (reg_re) begin
			unique case (reg_addr)
				ADDR_CTRL: begin
					reg_rdata <= ctrl_q;
					reg_rdata[B_STATE] <= cond_q;
				end
				ADDR_DAC: begin
					reg_rdata <= {DAC_PAD, dac_q};
				end
				default: begin
					reg_rdata <= RD_ZERO; // unmapped
				end
			endcase
		end else begin
			reg_rdata <= RD_ZERO;
		end
	end

	// polarity ahead of the catcher; gated off while disabled
	assign raw_pol = ctrl_q[B_ENABLE] &&
		(comp_raw ^ ctrl_q[B_POL]);

	// catcher: raw level sets it without a clock, so pulses far
	// shorter than a period survive; cleared once seen downstream
	always_ff @(posedge clk or posedge raw_pol) begin
		if (raw_pol) begin
			cap_q <= 1'b1;
		end else if (!rst_n) begin
			cap_q <= 1'b0;
		end else if (seen_q) begin
			cap_q <= 1'b0;
		end
	end

	// catcher is asynchronous to clk, so it is synchronised
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= cap_q;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts once the two late stages agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			seen_q <= s2_q;
		end
	end
	assign seen_rise = (s2_q == s3_q) && s2_q && !seen_q;

	// pwm clock arrives as a pin, sampled like any other input
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			p1_q <= 1'b0;
			p2_q <= 1'b0;
			p3_q <= 1'b0;
		end else begin
			p1_q <= pwm_clk_pin;
			p2_q <= p1_q;
			p3_q <= p2_q;
		end
	end

	// accepted pwm clock level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwm_lvl_q <= 1'b0;
		end else if (p2_q == p3_q) begin
			pwm_lvl_q <= p2_q;
		end
	end
	assign pwm_rise = (p2_q == p3_q) && p2_q && !pwm_lvl_q;

	// pwm ticks can never be closer than one system clock, so the
	// stretch still spans three system clocks in either mode
	assign tick = ctrl_q[B_FCLK_SEL] ? pwm_rise : 1'b1;

	// stretch: load on a new event, count down on ticks
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			hold_q <= CNT_ZERO;
		end else if (seen_rise) begin
			hold_q <= STRETCH_TICKS;
		end else if (tick && hold_q != CNT_ZERO) begin
			hold_q <= hold_q - CNT_ONE;
		end
	end
	assign stretched = run && (seen_q || hold_q != CNT_ZERO);

	// debounce filter on the same selected clock
	coc_filter u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.clear(!run),
		.tick(tick),
		.in_lvl(stretched),
		.out_lvl(filt_out)
	);

	// filter in the path only while enabled
	assign sel_lvl = ctrl_q[B_FILT_EN] ? filt_out : stretched;

	// conditioned output, forced low when stopped
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= run && sel_lvl;
		end
	end

	// consumers all fed at once: edge pulses and level paths
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			events <= '0;
		end else begin
			events.irq <= run && sel_lvl && !cond_q;
			events.adc_trigger <= run && sel_lvl && !cond_q;
			events.current_limit <= run && sel_lvl;
			events.period_trunc <= run && sel_lvl;
			events.fault <= run && sel_lvl;
		end
	end

	// wake pulse on a new event while asleep or idle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= (device_sleep || device_idle) && run &&
				sel_lvl && !cond_q;
		end
	end

	// own stop request shared with the other instances
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			idle_stop_request <= 1'b0;
		end else begin
			idle_stop_request <= ctrl_q[B_IDLE_STOP];
		end
	end

	// input mux; reserved alternate codes disconnect the input
	function automatic coc_mux_t mux_of(input logic alt,
		input logic [1:0] code);
		coc_mux_t m;
		m = MUX_OFF;
		if (!alt) begin
			unique case (code)
				2'h0: m = MUX_A;
				2'h1: m = MUX_B;
				2'h2: m = MUX_C;
				2'h3: m = MUX_D;
			endcase
		end else begin
			unique case (code)
				2'h0: m = MUX_AMP1;
				2'h1: m = MUX_AMP2;
				2'h2: m = MUX_OFF;
				2'h3: m = MUX_OFF;
			endcase
		end
		return m;
	endfunction

	// analog controls; powered down whenever the block stops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			analog.power_en <= 1'b0;
			analog.mux <= MUX_OFF;
			analog.ref_src <= REF_INTERNAL;
			analog.hyst_sel <= 2'h0;
			analog.hyst_pol <= 1'b0;
			analog.ref_pin_oe <= 1'b0;
			analog.dac_code <= DAC_RESET;
		end else begin
			analog.power_en <= run;
			analog.mux <= mux_of(ctrl_q[B_ALT],
				ctrl_q[B_INPUT_SELECT_HI:B_INPUT_SELECT_LO]);
			if (ctrl_q[B_EXT_REF]) begin
				analog.ref_src <= REF_EXTERNAL;
			end else if (ctrl_q[B_RANGE]) begin
				analog.ref_src <= REF_SUPPLY;
			end else begin
				analog.ref_src <= REF_INTERNAL;
			end
			analog.hyst_sel <= ctrl_q[B_HYS_HI:B_HYS_LO];
			analog.hyst_pol <= ctrl_q[B_HYS_POL];
			// one enabled pin per system is software's duty
			analog.ref_pin_oe <= ctrl_q[B_REF_OE];
			analog.dac_code <= dac_q;
		end
	end

	// checks on the conditioning path, analog controls and register access
	a_stretch_width: assert property (@(posedge clk)
		disable iff (!rst_n) $rose(stretched) |-> stretched [*3])
		else $error("stretched pulse shorter than three clocks");
	a_filter_bypass: assert property (@(posedge clk)
		disable iff (!rst_n) (run && !ctrl_q[B_FILT_EN])
		|=> cond_q == $past(stretched))
		else $error("bypassed output does not follow stretcher");
	a_filter_stable: assert property (@(posedge clk)
		disable iff (!rst_n) (ctrl_q[B_FILT_EN] && !ctrl_q[B_FCLK_SEL]
		&& $changed(filt_out) && run) |-> $past(stretched) == filt_out
		&& $past(stretched, 2) == filt_out
		&& $past(stretched, 3) == filt_out)
		else $error("filter passed a level held under three samples");
	a_disable_quiet: assert property (@(posedge clk)
		disable iff (!rst_n) !ctrl_q[B_ENABLE] |=> !cond_q &&
		!analog.power_en && !events.current_limit)
		else $error("disabled block still active");
	a_idle_stop: assert property (@(posedge clk)
		disable iff (!rst_n) (device_idle && idle_stop_others)
		|=> !analog.power_en && !cond_q)
		else $error("idle stop from another instance ignored");
	a_ref_pin: assert property (@(posedge clk)
		disable iff (!rst_n) 1'b1 |=>
		analog.ref_pin_oe == $past(ctrl_q[B_REF_OE]))
		else $error("reference pin enable does not follow bit 8");
	a_alt_reserved: assert property (@(posedge clk)
		disable iff (!rst_n) (ctrl_q[B_ALT] && ctrl_q[B_INPUT_SELECT_HI])
		|=> analog.mux == MUX_OFF)
		else $error("reserved alternate code selected an input");
	a_supply_ref: assert property (@(posedge clk)
		disable iff (!rst_n) (!ctrl_q[B_EXT_REF] && ctrl_q[B_RANGE])
		|=> analog.ref_src == REF_SUPPLY)
		else $error("range bit did not select analog supply");
	a_dac_write: assert property (@(posedge clk)
		disable iff (!rst_n) (reg_we && reg_addr == ADDR_DAC)
		|=> ##1 analog.dac_code == $past(reg_wdata[DAC_W-1:0], 2))
		else $error("threshold code not forwarded");
	a_consumers: assert property (@(posedge clk)
		disable iff (!rst_n) $rose(cond_q) |-> events.irq &&
		events.adc_trigger && events.fault ##1 !events.irq)
		else $error("consumers not driven together");
	a_status_read: assert property (@(posedge clk)
		disable iff (!rst_n) (reg_re && reg_addr == ADDR_CTRL)
		|=> reg_rdata[B_STATE] == $past(cond_q))
		else $error("status bit does not show conditioned output");

	// main scenarios
	c_filtered_event: cover property (@(posedge clk)
		disable iff (!rst_n) ctrl_q[B_FILT_EN] && $rose(cond_q));
	c_pwm_stretch: cover property (@(posedge clk)
		disable iff (!rst_n) ctrl_q[B_FCLK_SEL] && $fell(stretched));
	c_wake: cover property (@(posedge clk)
		disable iff (!rst_n) wake_request);
endmodule

// ---- test/coc_comp_model.sv ----
// behavioural model of the analog comparator and its threshold converter
module coc_comp_model (
	input wire coc_pkg::coc_analog_t analog,
	input wire logic [5:0][coc_pkg::DAC_W-1:0] volts,
	input wire logic glitch,
	output logic comp_raw
);
	import coc_pkg::*;
	logic sel_above; // selected input sits above the threshold
	// input mux: primary a to d, then both amplifier outputs
	always_comb begin
		sel_above = 1'b0;
		// reserved codes select nothing, so no result can leak through
		if (analog.mux != MUX_OFF)
			sel_above = volts[analog.mux] > analog.dac_code;
	end
	// a powered down comparator gives no result; spikes need power too
	assign comp_raw = analog.power_en & (sel_above | glitch);
endmodule

// ---- test/coc_top_tb_top.sv ----
// register and event bench for the comparator conditioning block
module coc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import coc_pkg::*;
	logic clk; // system clock
	logic rst_n; // active low reset
	logic [ADDR_W-1:0] reg_addr;
	logic [CTRL_W-1:0] reg_wdata;
	logic reg_we;
	logic reg_re;
	logic [CTRL_W-1:0] reg_rdata;
	logic comp_raw;
	logic pwm_clk_pin = 1'b0; // only the divider process drives it
	logic [3:0] pwm_div = 4'h0; // divides clk by sixteen for the pwm clock
	logic device_idle;
	logic device_sleep;
	logic idle_stop_others;
	logic idle_stop_request;
	coc_analog_t analog;
	coc_event_t events;
	logic wake_request;
	logic [5:0][DAC_W-1:0] volts; // levels on the six comparator inputs
	logic glitch; // spike far shorter than a clock period
	logic [CTRL_W-1:0] rv; // read result
	int n_mismatch;
	int checks_done;
	int n_hi, n_irq, n_adc, n_wake, n_bad, lat, lat_n;
	localparam logic [CTRL_W-1:0] RW[4] = '{16'h8020, 16'h8001,
		16'h8100, 16'h8021};
	localparam coc_ref_t RE[4] = '{REF_EXTERNAL, REF_SUPPLY, REF_INTERNAL,
		REF_EXTERNAL};
	coc_top coc_top_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(reg_rdata), .comp_raw(comp_raw),
		.pwm_clk_pin(pwm_clk_pin), .device_idle(device_idle),
		.device_sleep(device_sleep), .idle_stop_others(idle_stop_others),
		.idle_stop_request(idle_stop_request), .analog(analog),
		.events(events), .wake_request(wake_request));
	coc_comp_model coc_comp_model_i (.analog(analog), .volts(volts),
		.glitch(glitch), .comp_raw(comp_raw));
	// free running system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// pwm clock unrelated to register traffic, period sixteen clocks
	always @(posedge clk) begin
		pwm_div <= pwm_div + 4'h1;
		pwm_clk_pin <= pwm_div[3];
	end
	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#400000;
		n_mismatch++;
		summarize();
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk_word(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// boolean outcomes such as counts within bounds
	task automatic chk_flag(input string what, input logic ok);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] %s expected 1 seen %b", what, ok);
		end
	endtask
	// one strobe cycle, released at the next edge
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// count conditioned output cycles, pulses and the first high cycle
	task automatic watch(input int n);
		n_hi = 0;
		n_irq = 0;
		n_adc = 0;
		n_wake = 0;
		n_bad = 0;
		lat = -1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			if (events.current_limit === 1'b1) begin
				n_hi++;
				if (lat < 0)
					lat = i;
			end
			n_irq += int'(events.irq === 1'b1);
			n_adc += int'(events.adc_trigger === 1'b1);
			n_wake += int'(wake_request === 1'b1);
			n_bad += int'(events.fault !== events.current_limit);
			n_bad += int'(events.period_trunc !== events.current_limit);
		end
	endtask
	task automatic spike();
		@(negedge clk);
		glitch = 1'b1;
		#3 glitch = 1'b0;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		device_idle = 1'b0;
		device_sleep = 1'b0;
		idle_stop_others = 1'b0;
		volts = '0;
		glitch = 1'b0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL, rv);
		chk_word("ctrl reset", 16'h0000, rv);
		rd(ADDR_DAC, rv);
		chk_word("dac reset", 16'h0000, rv);
		// select code 00 with the alternate bit clear is input a
		chk_word("mux reset", {13'h0, MUX_A}, {13'h0, analog.mux});
		// bit 14 unused, bit 3 hardware owned and low while disabled
		wr(ADDR_CTRL, 16'h7FFF);
		rd(ADDR_CTRL, rv);
		chk_word("ctrl rw", 16'h3FF7, rv);
		chk_flag("idle stop out", idle_stop_request === 1'b1);
		chk_flag("power off", analog.power_en === 1'b0);
		// hysteresis fields pass straight through to the comparator
		chk_word("hyst", {13'h0, 2'h3, 1'b1},
			{13'h0, analog.hyst_sel, analog.hyst_pol});
		rd(4'h5, rv);
		chk_word("unmapped", 16'h0000, rv);
		wr(ADDR_DAC, 16'hFABC);
		rd(ADDR_DAC, rv);
		chk_word("dac rw", 16'h0ABC, rv);
		chk_word("dac out", 16'h0ABC, {4'h0, analog.dac_code});
		// every select code, plain then alternate
		for (int k = 0; k < 8; k++) begin
			wr(ADDR_CTRL, {8'h80, k[1:0], 3'h0, k[2], 2'h0});
			@(posedge clk);
			#1;
			chk_word("mux", (k < 6) ? k[15:0] : {13'h0, MUX_OFF},
				{13'h0, analog.mux});
		end
		// reference source for each control word, with the reference pin enable following bit 8
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_CTRL, RW[k]);
			@(posedge clk);
			#1;
			chk_word("ref", {14'h0, RE[k]}, {14'h0, analog.ref_src});
			chk_flag("ref pin", analog.ref_pin_oe === RW[k][8]);
			chk_flag("power on", analog.power_en === 1'b1);
		end
		// sub-cycle spike while asleep
		wr(ADDR_DAC, 16'h0100);
		wr(ADDR_CTRL, 16'h8000);
		device_sleep <= 1'b1;
		spike();
		watch(20);
		chk_flag("stretch", n_hi >= 3);
		chk_flag("irq once", n_irq == 1 && n_adc == 1);
		chk_flag("levels agree", n_bad == 0);
		chk_flag("wake", n_wake == 1);
		device_sleep <= 1'b0;
		// inverted polarity turns a low input into a high status
		wr(ADDR_CTRL, 16'h8002);
		watch(12);
		rd(ADDR_CTRL, rv);
		chk_word("status inv", 16'h800A, rv);
		wr(ADDR_CTRL, 16'h8008);
		watch(12);
		rd(ADDR_CTRL, rv);
		chk_word("status ro", 16'h8000, rv);
		// latency of a steady rise, without and with the filter
		volts[0] <= 12'h800;
		watch(20);
		lat_n = lat;
		volts[0] <= 12'h000;
		wr(ADDR_CTRL, 16'h8400);
		watch(20);
		volts[0] <= 12'h800;
		watch(20);
		chk_flag("filter delay", lat >= lat_n + 2 && lat_n >= 0);
		volts[0] <= 12'h000;
		// stretch counted in slow pwm ticks
		wr(ADDR_CTRL, 16'h8200);
		watch(60);
		spike();
		watch(80);
		chk_flag("pwm stretch", n_hi >= 32);
		// idle stop from another instance, then from this one
		wr(ADDR_CTRL, 16'h8002);
		device_idle <= 1'b1;
		idle_stop_others <= 1'b1;
		watch(12);
		chk_flag("idle others", events.current_limit === 1'b0);
		// own stop bit first, so the block never runs for a cycle between
		wr(ADDR_CTRL, 16'hA002);
		idle_stop_others <= 1'b0;
		watch(12);
		chk_flag("idle own", events.current_limit === 1'b0);
		device_idle <= 1'b0;
		watch(12);
		chk_flag("idle left", events.current_limit === 1'b1);
		wr(ADDR_CTRL, 16'h0002);
		watch(12);
		chk_flag("disabled", events.current_limit === 1'b0);
		chk_flag("disabled power", analog.power_en === 1'b0);
		summarize();
	end
endmodule
